// file: src/tofu_pkg.sv
// Constants and carrier types for the time-of-flight timestamp unit
package tofu_pkg;
   // Register map
   localparam logic [7:0] TOFU_CTRL_ADDR     = 8'h03;  // transceiver_control_zero
   localparam logic [7:0] TOFU_RXCTRL_ADDR   = 8'h0A;  // Sync shift read-back
   localparam logic [7:0] TOFU_CTRL_RESET    = 8'h09;  // Value after reset
   localparam logic [7:0] TOFU_CTRL_WMASK    = 8'hBF;  // Bit 6 reads as zero
   localparam int         TOFU_EN_BIT        = 7;      // tof_enable position
   localparam int         TOFU_SHIFT_LSB     = 6;      // Shift field at bits 7:6
   // Frame buffer result area
   localparam logic [6:0] TOFU_RES_BASE      = 7'h73;  // First result byte
   localparam int         TOFU_RES_BYTES     = 13;     // 0x73 .. 0x7F
   localparam int         TOFU_CPM_COUNT     = 9;      // Correlator samples
   localparam int         TOFU_FEC_IDX       = 9;      // 0x7C
   localparam int         TOFU_TIM_IDX       = 10;     // 0x7D .. 0x7F
   localparam logic [7:0] TOFU_PSDU_TOF      = 8'd114; // Usable length with results
   localparam logic [7:0] TOFU_PSDU_FULL     = 8'd127; // Usable length without
   localparam logic [7:0] TOFU_SFD_STD       = 8'hA7;  // Standard delimiter
   // Timing
   localparam int         TOFU_CLK_NS        = 100;    // core_clk period
   localparam int         TOFU_TX_DELAY_PS   = 16125000; // 16.125 us
   localparam int         TOFU_RX_DELAY_US   = 80;     // 80 us
   localparam int         TOFU_TX_DLY_CYC    = (TOFU_TX_DELAY_PS + TOFU_CLK_NS * 1000 - 1)
                                               / (TOFU_CLK_NS * 1000);
   localparam int         TOFU_RX_DLY_CYC    = (TOFU_RX_DELAY_US * 1000 + TOFU_CLK_NS - 1)
                                               / TOFU_CLK_NS;
   localparam int         TOFU_CLK_MHZ       = 10;     // Core rate
   localparam int         TOFU_TC_MHZ        = 16;     // Timer/counter rate
   localparam logic [3:0] TOFU_ACC_STEP      = 4'h6;   // 16 mod 10
   localparam logic [3:0] TOFU_ACC_WRAP      = 4'hA;   // Accumulator modulus
   // Radio event carrier, one-cycle strobes plus their data
   typedef struct packed {
      logic       sfd_det;      // Receive synchronization found a delimiter
      logic [7:0] sfd_value;    // Delimiter value seen
      logic [1:0] sync_shift;   // Early/late indication at sync
      logic       rx_start;     // Receive start of a frame
      logic [6:0] phr_len;      // Length field of the frame
      logic       frame_done;   // frame_done_event
      logic       ack_rx;       // Acknowledgement frame received
   } tofu_rx_ev_t;
endpackage : tofu_pkg

// file: src/tofu_timestamp_unit.sv
// Time-of-flight timestamp unit: timer/counter, capture and result writer
`timescale 1ns/10ps
module tofu_timestamp_unit
   import tofu_pkg::*;
#(
   parameter int TC_WIDTH = 24               // Timer/counter width
) (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   sys_rst,
   // Register port
   input  wire logic [7:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_we,
   output logic      [7:0]             reg_rdata,
   // Pin and radio events
   input  wire logic                   sleep_trigger_pin,
   input  wire tofu_rx_ev_t            rx_ev,
   input  wire logic                   rx_start_irq_en,
   input  wire logic [7:0]             fec_in,
   input  wire logic [8*TOFU_CPM_COUNT-1:0] cpm_in,
   // Interrupt and status
   output logic                        rx_start_irq,
   output logic                        tof_enable,
   output logic      [7:0]             psdu_limit,
   output logic                        results_corrupt,
   // Frame buffer write port
   output logic                        fb_we,
   output logic      [6:0]             fb_addr,
   output logic      [7:0]             fb_wdata
);

   localparam logic [9:0] TX_DLY = 10'(TOFU_TX_DLY_CYC);  // Cycles of trigger delay
   localparam logic [9:0] RX_DLY = 10'(TOFU_RX_DLY_CYC);  // Cycles of sync delay

   logic [7:0]          ctrl_reg;        // transceiver_control_zero
   logic [1:0]          shift_reg;       // sync_shift_indication
   logic                pin_s1_reg;      // Synchroniser first stage
   logic                pin_s2_reg;      // Synchroniser second stage
   logic                pin_s3_reg;      // Edge history
   logic [TC_WIDTH-1:0] count_reg;       // Timer/counter
   logic                run_reg;         // Counter started
   logic [3:0]          acc_reg;         // Fractional rate accumulator
   logic [9:0]          tx_dly_reg;      // Trigger delay down-counter
   logic [9:0]          rx_dly_reg;      // Sync delay down-counter
   logic                rx_restart_reg;  // Pending sync restarts counter
   logic [TC_WIDTH-1:0] ts_reg;          // Captured timestamp
   logic [7:0]          res_reg [TOFU_RES_BYTES];  // Result shadow bytes
   logic [TOFU_RES_BYTES-1:0] dirty_reg; // Bytes still to write out
   logic [TOFU_RES_BYTES-1:0] dirty_set; // Bytes refreshed this cycle
   logic                pin_rise;        // Trigger rising edge
   logic                tx_fire;         // Trigger delay elapsed
   logic                rx_fire;         // Sync delay elapsed
   logic                capture;         // Capture in this cycle
   logic                restart;         // Clear and restart in this cycle
   logic [1:0]          tc_inc;          // Ticks this core cycle
   logic [3:0]          acc_sum;         // Accumulator before wrap
   logic [3:0]          wr_idx;          // Byte chosen for writing

   // Lowest set bit of a dirty mask, used for picking and clearing
   function automatic logic [3:0] first_set(input logic [TOFU_RES_BYTES-1:0] m);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = TOFU_RES_BYTES - 1; i >= 0; i--) begin
         if (m[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : first_set

   assign tof_enable = ctrl_reg[TOFU_EN_BIT];

   // Control register write; bit 6 stays zero
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg <= TOFU_CTRL_RESET;
      end else if (reg_we && reg_addr == TOFU_CTRL_ADDR) begin
         ctrl_reg <= reg_wdata & TOFU_CTRL_WMASK;
      end
   end

   // Read mux; unmapped addresses answer zero
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == TOFU_CTRL_ADDR) begin
         reg_rdata <= ctrl_reg;
      end else if (reg_addr == TOFU_RXCTRL_ADDR) begin
         reg_rdata <= {shift_reg, 6'h00};
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Sync shift is sampled at every delimiter detection
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= 2'h0;
      end else if (rx_ev.sfd_det) begin
         shift_reg <= rx_ev.sync_shift;
      end
   end

   // The trigger pin is asynchronous; edge detect only past stage two
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         pin_s3_reg <= 1'b0;
      end else begin
         pin_s1_reg <= sleep_trigger_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end
   assign pin_rise = pin_s2_reg & ~pin_s3_reg;

   // Trigger delay; a new edge while pending restarts the wait
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_dly_reg <= 10'h000;
      end else if (pin_rise && tof_enable) begin
         tx_dly_reg <= TX_DLY;
      end else if (tx_dly_reg != 10'h000) begin
         tx_dly_reg <= tx_dly_reg - 10'h001;
      end
   end
   assign tx_fire = (tx_dly_reg == 10'h001);

   // Sync delay, remembering whether the delimiter was the standard one
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_dly_reg     <= 10'h000;
         rx_restart_reg <= 1'b0;
      end else if (rx_ev.sfd_det && tof_enable) begin
         rx_dly_reg     <= RX_DLY;
         rx_restart_reg <= (rx_ev.sfd_value == TOFU_SFD_STD);
      end else if (rx_dly_reg != 10'h000) begin
         rx_dly_reg <= rx_dly_reg - 10'h001;
      end
   end
   assign rx_fire = (rx_dly_reg == 10'h001);

   assign capture = tx_fire | rx_fire;
   assign restart = tx_fire | (rx_fire & rx_restart_reg);

   // 16 MHz from a 10 MHz core: 1.6 ticks per cycle by a fractional step
   assign acc_sum = acc_reg + TOFU_ACC_STEP;
   assign tc_inc  = (acc_sum >= TOFU_ACC_WRAP) ? 2'd2 : 2'd1;

   // Fractional accumulator only runs while the counter does
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_reg <= 4'h0;
      end else if (restart) begin
         acc_reg <= 4'h0;
      end else if (run_reg) begin
         acc_reg <= (acc_sum >= TOFU_ACC_WRAP) ? acc_sum - TOFU_ACC_WRAP : acc_sum;
      end
   end

   // Counter: started by the first restarting event, wraps silently
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_reg <= '0;
         run_reg   <= 1'b0;
      end else if (!tof_enable) begin
         count_reg <= '0;
         run_reg   <= 1'b0;
      end else if (restart) begin
         count_reg <= '0;
         run_reg   <= 1'b1;
      end else if (run_reg) begin
         count_reg <= count_reg + TC_WIDTH'(tc_inc);
      end
   end

   // Capture takes the value before any clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ts_reg <= '0;
      end else if (capture) begin
         ts_reg <= count_reg;
      end
   end

   // Which result bytes are refreshed this cycle
   always_comb begin
      dirty_set = '0;
      if (tof_enable) begin
         if (rx_ev.sfd_det) begin
            dirty_set[TOFU_CPM_COUNT-1:0] = '1;
         end
         if (rx_ev.rx_start || rx_ev.frame_done) begin
            dirty_set[TOFU_FEC_IDX] = 1'b1;
         end
         if (capture) begin
            dirty_set[TOFU_RES_BYTES-1:TOFU_TIM_IDX] = '1;
         end
         if (rx_ev.ack_rx) begin
            dirty_set = '1;
         end
      end
   end

   // Result shadow: correlator samples, estimate, timestamp bytes
   generate
      for (genvar k = 0; k < TOFU_CPM_COUNT; k++) begin : g_cpm
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               res_reg[k] <= 8'h00;
            end else if (rx_ev.sfd_det && tof_enable) begin
               res_reg[k] <= cpm_in[8*k +: 8];
            end
         end
      end
      for (genvar t = 0; t < 3; t++) begin : g_tim
         assign res_reg[TOFU_TIM_IDX+t] = ts_reg[8*t +: 8];
      end
   endgenerate

   // Estimate is passed through unchanged as a two's complement byte
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         res_reg[TOFU_FEC_IDX] <= 8'h00;
      end else if (tof_enable && (rx_ev.rx_start || rx_ev.frame_done)) begin
         res_reg[TOFU_FEC_IDX] <= fec_in;
      end
   end

   // Pending writes; a refresh in the write cycle keeps the byte pending
   assign wr_idx = first_set(dirty_reg);
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dirty_reg <= '0;
      end else if (!tof_enable) begin
         dirty_reg <= '0;
      end else if (dirty_reg != '0) begin
         dirty_reg <= (dirty_reg & ~(TOFU_RES_BYTES'(1) << wr_idx)) | dirty_set;
      end else begin
         dirty_reg <= dirty_set;
      end
   end

   // One byte per cycle into the reserved top of the frame buffer
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fb_we    <= 1'b0;
         fb_addr  <= 7'h00;
         fb_wdata <= 8'h00;
      end else begin
         fb_we    <= (dirty_reg != '0) && tof_enable;
         fb_addr  <= TOFU_RES_BASE + 7'(wr_idx);
         fb_wdata <= res_reg[wr_idx];
      end
   end

   // Receive-start interrupt; with the mode on, empty frames still count
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_start_irq <= 1'b0;
      end else begin
         rx_start_irq <= rx_ev.rx_start && rx_start_irq_en
                         && (tof_enable || rx_ev.phr_len != 7'h00);
      end
   end

   // Usable length and overrun of the result area by a long frame
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         psdu_limit      <= TOFU_PSDU_FULL;
         results_corrupt <= 1'b0;
      end else begin
         psdu_limit <= tof_enable ? TOFU_PSDU_TOF : TOFU_PSDU_FULL;
         if (rx_ev.rx_start) begin
            results_corrupt <= tof_enable && ({1'b0, rx_ev.phr_len} > TOFU_PSDU_TOF);
         end
      end
   end

   // Checks
   tc_wrap_a : assert property (@(posedge core_clk) disable iff (sys_rst)
      (run_reg && tof_enable && !restart && $past(run_reg) && !$past(restart) && $past(tof_enable))
      |-> (count_reg == $past(count_reg) + TC_WIDTH'($past(tc_inc))))
      else $error("counter did not advance by its tick count");
   tc_rate_a : assert property (@(posedge core_clk) disable iff (sys_rst)
      (run_reg && !restart && tc_inc == 2'd1) |=> (tc_inc == 2'd2))
      else $error("rate accumulator out of step");
   tx_delay_a : assert property (@(posedge core_clk) disable iff (sys_rst)
      (pin_rise && tof_enable) |-> ##162 (tx_fire || tx_dly_reg > 10'h001))
      else $error("trigger capture delay wrong");
   rx_delay_a : assert property (@(posedge core_clk) disable iff (sys_rst)
      (rx_ev.sfd_det && tof_enable) |=> (rx_dly_reg == RX_DLY))
      else $error("sync delay not loaded");
   restart_clr_a : assert property (@(posedge core_clk) disable iff (sys_rst)
      (restart && tof_enable) |=> (count_reg == '0) && (ts_reg == $past(count_reg)) && run_reg)
      else $error("capture or restart wrong");
   nonstd_keep_a : assert property (@(posedge core_clk) disable iff (sys_rst)
      (rx_fire && !rx_restart_reg && !tx_fire && run_reg && tof_enable) |=>
      (count_reg != '0 || $past(count_reg) != '0) && ts_reg == $past(count_reg))
      else $error("non-standard delimiter restarted counter");
   tim_write_a : assert property (@(posedge core_clk) disable iff (sys_rst)
      (fb_we && fb_addr == 7'h7D) |-> (fb_wdata == $past(ts_reg[7:0])))
      else $error("timestamp low byte mismatch");
   irq_empty_a : assert property (@(posedge core_clk) disable iff (sys_rst)
      (rx_ev.rx_start && rx_start_irq_en && tof_enable) |=> rx_start_irq)
      else $error("receive-start interrupt missing");
   ack_map_a : assert property (@(posedge core_clk) disable iff (sys_rst)
      (rx_ev.ack_rx && tof_enable) |=> (dirty_reg[TOFU_RES_BYTES-1] && dirty_reg[0]))
      else $error("acknowledgement did not map results");
   en_reset_a : assert property (@(posedge core_clk)
      $fell(sys_rst) |-> !tof_enable)
      else $error("mode enabled after reset");

endmodule : tofu_timestamp_unit

// file: tb/tofu_fb_model.sv
// Frame buffer model that stores every result byte the unit writes
`timescale 1ns/10ps
module tofu_fb_model (
   // Clock
   input  wire logic       core_clk,
   // Write port from the unit
   input  wire logic       fb_we,
   input  wire logic [6:0] fb_addr,
   input  wire logic [7:0] fb_wdata,
   // Bench control
   input  wire logic       fb_clr,
   // Host writes of outgoing frame bytes
   input  wire logic       host_we,
   input  wire logic [6:0] host_addr,
   input  wire logic [7:0] host_wdata
);
   logic [7:0] mem [0:127];  // Whole buffer, so stray writes below the result area show up
   // Store written bytes; clear fills a pattern so a missing rewrite cannot look fresh
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 128; i++) begin
         if (fb_clr) begin
            mem[i] <= 8'hEE;
         end else if (fb_we && fb_addr == i[6:0]) begin
            mem[i] <= fb_wdata;
         end else if (host_we && host_addr == i[6:0]) begin
            mem[i] <= host_wdata;
         end
      end
   end
endmodule : tofu_fb_model

// file: tb/tofu_timestamp_unit_bench.sv
// Self-checking bench for the time-of-flight timestamp unit
`timescale 1ns/10ps
module tofu_timestamp_unit_bench;
   import tofu_pkg::*;
   logic        core_clk, sys_rst, reg_we, slp, irq_en, fb_clr;  // Clock, reset, strobes
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, fec_in, psdu_limit; // Bytes
   logic [71:0] cpm_in;                                          // Correlator samples
   tofu_rx_ev_t rx_ev;                                           // Radio events
   logic        rx_start_irq, tof_enable, results_corrupt, fb_we; // Outputs
   logic [6:0]  fb_addr;                                         // Buffer address
   logic [7:0]  fb_wdata, d;                                     // Buffer data, read value
   logic [23:0] saved;                                           // Last timestamp
   logic        host_we;                                         // Host buffer write strobe
   logic [6:0]  host_addr;                                       // Host buffer address
   logic [7:0]  host_wdata;                                      // Host buffer data
   int          miscompares, samples_checked, n;                 // Counters
   tofu_timestamp_unit #(.TC_WIDTH(24)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
      .sleep_trigger_pin(slp), .rx_ev(rx_ev), .rx_start_irq_en(irq_en), .fec_in(fec_in),
      .cpm_in(cpm_in), .rx_start_irq(rx_start_irq), .tof_enable(tof_enable),
      .psdu_limit(psdu_limit), .results_corrupt(results_corrupt), .fb_we(fb_we),
      .fb_addr(fb_addr), .fb_wdata(fb_wdata));
   tofu_fb_model i_fb (.core_clk(core_clk), .fb_we(fb_we), .fb_addr(fb_addr),
      .fb_wdata(fb_wdata), .fb_clr(fb_clr), .host_we(host_we), .host_addr(host_addr),
      .host_wdata(host_wdata));
   // Free-running 10 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // Compare one value and count it
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Range compare for counter values, which step 1 or 2 per cycle
   task automatic near(input string name, input logic [23:0] v, input int lo, input int hi);
      check(name, {23'd0, (v >= lo && v <= hi)}, 24'd1);
   endtask : near
   // Wait whole cycles, ending at a falling edge
   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cyc
   // Register write: strobe held across one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_we = 1'b1;
      cyc(1);
      reg_we = 1'b0;
   endtask : wr
   // Register read: data is registered one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      reg_addr = a;
      cyc(1);
      v = reg_rdata;
   endtask : rd
   // Frame start with a length and estimate; counts interrupt pulses seen
   task automatic rx_frame(input logic [6:0] len, input logic [7:0] fec, output int cnt);
      rx_ev.phr_len = len;
      fec_in = fec;
      rx_ev.rx_start = 1'b1;
      cyc(1);
      rx_ev.rx_start = 1'b0;
      cnt = 0;
      repeat (3) begin
         if (rx_start_irq === 1'b1) cnt++;
         cyc(1);
      end
   endtask : rx_frame
   // Delimiter detection with a value and a shift code
   task automatic sfd(input logic [7:0] v, input logic [1:0] sh);
      rx_ev.sfd_value = v;
      rx_ev.sync_shift = sh;
      rx_ev.sfd_det = 1'b1;
      cyc(1);
      rx_ev.sfd_det = 1'b0;
   endtask : sfd
   // Timestamp bytes as the host sees them in the buffer
   function automatic logic [23:0] ts();
      return {i_fb.mem[127], i_fb.mem[126], i_fb.mem[125]};
   endfunction : ts
   // Print counts and verdict, then stop
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   // Watchdog so a stuck sequence still reaches the report
   initial begin
      #2000000;
      miscompares++;
      end_sim();
   end
   // Main sequence
   initial begin
      miscompares = 0;
      samples_checked = 0;
      {sys_rst, reg_we, slp, irq_en, fb_clr, host_we} = 6'b100100;
      {reg_addr, reg_wdata, fec_in, host_wdata} = '0;
      host_addr = 7'h00;
      rx_ev = '0;
      for (int k = 0; k < 9; k++) cpm_in[8*k+:8] = 8'(k * 17 + 1);
      cyc(20);
      sys_rst = 1'b0;
      rd(TOFU_CTRL_ADDR, d);
      check("ctrl_reset", 24'(d), 24'(TOFU_CTRL_RESET));
      check("tof_off", 24'(tof_enable), 24'h000000);
      check("limit_off", 24'(psdu_limit), 24'(TOFU_PSDU_FULL));
      // Mode off: empty frames stay silent, others interrupt
      rx_frame(7'd0, 8'h00, n);
      check("irq_off_empty", 24'(n), 24'h000000);
      rx_frame(7'd5, 8'h00, n);
      check("irq_off_len", 24'(n), 24'h000001);
      wr(TOFU_CTRL_ADDR, 8'hFF);
      rd(TOFU_CTRL_ADDR, d);
      check("ctrl_rw", 24'(d), 24'h0000BF);
      check("tof_on", 24'(tof_enable), 24'h000001);
      check("limit_on", 24'(psdu_limit), 24'(TOFU_PSDU_TOF));
      rd(8'h55, d);
      check("unmapped", 24'(d), 24'h000000);
      // Mode on: empty frame interrupts and stores the estimate
      fb_clr = 1'b1;
      cyc(1);
      fb_clr = 1'b0;
      rx_frame(7'd0, 8'h9C, n);
      check("irq_on_empty", 24'(n), 24'h000001);
      cyc(20);
      check("fec_start", 24'(i_fb.mem[124]), 24'h00009C);
      fec_in = 8'h31;
      rx_ev.frame_done = 1'b1;
      cyc(1);
      rx_ev.frame_done = 1'b0;
      cyc(20);
      check("fec_end", 24'(i_fb.mem[124]), 24'h000031);
      irq_en = 1'b0;
      rx_frame(7'd120, 8'h31, n);
      check("irq_masked", 24'(n), 24'h000000);
      check("corrupt_long", 24'(results_corrupt), 24'h000001);
      irq_en = 1'b1;
      rx_frame(7'd114, 8'h31, n);
      check("corrupt_edge", 24'(results_corrupt), 24'h000000);
      // Pin edge restarts the counter, standard delimiter captures and restarts
      slp = 1'b1;
      cyc(200);
      check("ts_pin_first", ts(), 24'h000000);
      // Host fills the result area after the start, as a long outgoing frame would
      host_we = 1'b1;
      for (int k = 0; k < 13; k++) begin
         host_addr = TOFU_RES_BASE + 7'(k);
         host_wdata = 8'h40 + 8'(k);
         cyc(1);
      end
      host_we = 1'b0;
      cyc(187);
      check("host_tail", 24'(i_fb.mem[127]), 24'h00004C);
      sfd(TOFU_SFD_STD, 2'd2);
      cyc(819);
      slp = 1'b0;
      near("ts_pin_to_std", ts(), 1640, 1672);
      for (int k = 0; k < 9; k++) check("cpm", 24'(i_fb.mem[115 + k]), 24'(k * 17 + 1));
      rd(TOFU_RXCTRL_ADDR, d);
      check("shift_late", 24'(d), 24'h000080);
      // Two other delimiters: capture only, so the count keeps growing
      sfd(8'h5A, 2'd1);
      cyc(819);
      near("ts_other_1", ts(), 1309, 1315);
      rd(TOFU_RXCTRL_ADDR, d);
      check("shift_early", 24'(d), 24'h000040);
      sfd(8'h5A, 2'd0);
      cyc(819);
      near("ts_other_2", ts(), 2621, 2627);
      saved = ts();
      // Acknowledgement maps all results back into a cleared buffer
      fb_clr = 1'b1;
      cyc(1);
      fb_clr = 1'b0;
      rx_ev.ack_rx = 1'b1;
      cyc(1);
      rx_ev.ack_rx = 1'b0;
      cyc(30);
      check("ack_ts", ts(), saved);
      check("ack_fec", 24'(i_fb.mem[124]), 24'h000031);
      check("ack_cpm", 24'(i_fb.mem[115]), 24'h000001);
      end_sim();
   end
endmodule : tofu_timestamp_unit_bench
